// ===== peripheral_pin_select_bench.sv
// peripheral_pin_select_bench.sv: self checking bench for pps_top
// assumes: pps_far_model stands in for peripherals and pads
`timescale 1ns/100ps
`default_nettype none
module peripheral_pin_select_bench;
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wr;
    logic [31:0] rd;
  } pps_row_t;
  logic         mclk, rst, ce, psel, penable, pwrite;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, rdata;
  logic [3:0]   pstrb, pin_out, pin_out_en, e, o;
  logic         pready, pslverr, err, flip, enc_on;
  logic         spi_clk, spi_dat, fault1, capt1;
  logic [127:0] pin_in;
  logic [5:0]   virt, f, g;
  logic [3:0]   enc;
  logic [63:0]  func;
  logic [6:0]   c, d;
  int           mismatches, checks_done, cycles;
  pps_row_t rows [6] = '{
    '{12'h000, 32'hffffffff, 32'h00007f7f},
    '{12'h004, 32'hffffffff, 32'h00003f3f},
    '{12'h008, 32'hffffffff, 32'h00003f3f},
    '{12'h00c, 32'hffffffff, 32'h0000007f},
    '{12'h010, 32'h0000ffff, 32'h0000007f},
    '{12'h000, 32'h00001234, 32'h00001234}};
  logic [6:0] codes [12] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h05,
                             7'h06, 7'h07, 7'h08, 7'h09, 7'h0a, 7'h79};
  logic [5:0] funcs [4] = '{6'h00, 6'h01, 6'h02, 6'h3f};

  pps_top #(.NPINS(128), .NFUNCS(64), .HAS_ENC(1'b1)) pps_top_i (
    .MCLK(mclk), .RST(rst), .CE(ce), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb),
    .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr),
    .PIN_IN(pin_in), .VIRT_SRC(virt), .ENC_FILTERED(enc),
    .FUNC_OUT(func), .SPI2_CLK_IN(spi_clk), .SPI2_DATA_IN(spi_dat),
    .PWM_FAULT1_IN(fault1), .CAPTURE1_IN(capt1),
    .PIN_OUT(pin_out), .PIN_OUT_EN(pin_out_en));
  pps_far_model #(.NPINS(128), .NFUNCS(64)) pps_far_model_i (
    .flip(flip), .enc_on(enc_on), .pin_in(pin_in), .virt(virt),
    .enc(enc), .func(func));

  task automatic chk_bit(input logic gt, input logic ex);
    checks_done++;
    if (gt !== ex)
    begin
      mismatches++;
      $display("[FAIL] %0t bit got %b want %b", $time, gt, ex);
    end
  endtask
  task automatic chk_word(input logic [31:0] gt, input logic [31:0] ex);
    checks_done++;
    if (gt !== ex)
    begin
      mismatches++;
      $display("[FAIL] %0t word got %h want %h", $time, gt, ex);
    end
  endtask
  task automatic wrap_up;
    $display("mismatches %0d checks %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] dt, input logic [3:0] s);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dt;
    pstrb <= s;
    @(posedge mclk);
    penable <= 1'b1;
    // only the bench timeout ends a wait that never sees pready
    do
      @(posedge mclk);
    while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] dt);
    apb(1'b1, a, dt, 4'hf);
  endtask
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0, 4'hf);
  endtask
  // routed outputs lag the write edge by one cycle
  task automatic settle;
    repeat (2) @(posedge mclk);
  endtask
  function automatic logic src(input logic [6:0] k);
    if (k == 7'h00)
      return 1'b0;
    if (k <= 7'h05)
      return virt[k-7'h01];
    if (k <= 7'h09)
      return enc[k-7'h06];
    return pin_in[k];
  endfunction

  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      wrap_up();
    end
  end

  initial
  begin
    {rst, ce} = 2'b11;
    {psel, penable, pwrite, flip} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    enc_on = 1'b1;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++)
    begin
      wr(rows[i].addr, rows[i].wr);
      rd(rows[i].addr);
      chk_word(rdata, rows[i].rd);
    end
    rst <= 1'b1;
    @(posedge mclk);
    rst <= 1'b0;
    #1;
    chk_word({20'h0, spi_clk, spi_dat, fault1, capt1, pin_out,
              pin_out_en}, 32'h0);
    for (int a = 0; a < 20; a += 4)
    begin
      rd(a[11:0]);
      chk_word(rdata, 32'h0);
    end
    for (int fl = 0; fl < 2; fl++)
      for (int i = 0; i < 12; i++)
      begin
        flip <= fl[0];
        c = codes[i];
        d = codes[11-i];
        wr(12'h000, {16'h0, 1'b0, c, 1'b0, d});
        wr(12'h00c, {25'h0, c});
        wr(12'h010, {25'h0, d});
        settle();
        chk_bit(spi_clk, src(c));
        chk_bit(spi_dat, src(d));
        chk_bit(fault1, src(c));
        chk_bit(capt1, src(d));
      end
    for (int i = 0; i < 4; i++)
    begin
      f = funcs[i];
      g = 6'h3f - f;
      wr(12'h004, {18'h0, f, 2'b00, g});
      wr(12'h008, {18'h0, g, 2'b00, f});
      settle();
      e = {g != 6'h0, f != 6'h0, f != 6'h0, g != 6'h0};
      o = {func[g], func[f], func[f], func[g]};
      chk_word({28'h0, pin_out_en}, {28'h0, e});
      chk_word({28'h0, pin_out & e}, {28'h0, o & e});
    end
    // unmapped place refuses both directions
    wr(12'h014, 32'hffffffff);
    chk_bit(err, 1'b1);
    rd(12'h014);
    chk_bit(err, 1'b1);
    chk_word(rdata, 32'h0);
    // low enable must freeze the routed level while the pin moves
    wr(12'h000, 32'h00000a0a);
    settle();
    chk_bit(spi_dat, flip);
    ce <= 1'b0;
    flip <= ~flip;
    settle();
    chk_bit(spi_dat, ~flip);
    ce <= 1'b1;
    settle();
    chk_bit(spi_dat, flip);
    wr(12'h000, 32'h0);
    apb(1'b1, 12'h000, 32'h00007f7f, 4'h2);
    rd(12'h000);
    chk_word(rdata, 32'h00007f00);
    wrap_up();
  end
endmodule
`default_nettype wire

// ===== pps_defines.svh
// pps_defines.svh: offsets, field positions, reset values and codes
// assumes: included by the pin select modules by bare name
`ifndef PPS_DEFINES_SVH
`define PPS_DEFINES_SVH

`define PPS_OFF_SPI2_IN     12'h000
`define PPS_OFF_OUT_42_43   12'h004
`define PPS_OFF_OUT_54_55   12'h008
`define PPS_OFF_PFAULT_IN   12'h00c
`define PPS_OFF_CAPTURE_IN  12'h010

`define PPS_IN_W            7
`define PPS_OUT_W           6
`define PPS_IN_HI_LSB       8
`define PPS_IN_LO_LSB       0
`define PPS_OUT_HI_LSB      8
`define PPS_OUT_LO_LSB      0

`define PPS_IN_MASK         32'h00007f7f
`define PPS_OUT_MASK        32'h00003f3f
`define PPS_RESET_VAL       32'h00000000

`define PPS_CODE_LOW        7'h00
`define PPS_CODE_COMP1      7'h01
`define PPS_CODE_COMP2      7'h02
`define PPS_CODE_COMP3      7'h03
`define PPS_CODE_TRIG0      7'h04
`define PPS_CODE_TRIG1      7'h05
`define PPS_CODE_INDX_A     7'h06
`define PPS_CODE_HOME_A     7'h07
`define PPS_CODE_INDX_B     7'h08
`define PPS_CODE_HOME_B     7'h09
`define PPS_CODE_PIN_MAX    7'h79

`endif

// ===== pps_far_model.sv
// pps_far_model.sv: peripherals and pads beside the pin select
// assumes: levels are static between bench steps
`timescale 1ns/100ps
`default_nettype none
module pps_far_model #(
  parameter int NPINS  = 128,
  parameter int NFUNCS = 64
)(
  input  wire logic         flip,
  input  wire logic         enc_on,
  output logic [NPINS-1:0]  pin_in,
  output logic [5:0]        virt,
  output logic [3:0]        enc,
  output logic [NFUNCS-1:0] func
);
  // pins alternate levels, functions alternate in pairs, so a wrong pick shows up
  always_comb
  begin
    for (int n = 0; n < NPINS; n++)
      pin_in[n] = n[0] ^ flip;
    for (int f = 0; f < NFUNCS; f++)
      func[f] = f[1] ^ flip;
  end
  assign virt = 6'h15 ^ {6{flip}};
  // filter output stays dead until software enables the encoder
  assign enc = enc_on ? (4'h5 ^ {4{flip}}) : 4'h0;
endmodule
`default_nettype wire

// ===== pps_in_mux.sv
// pps_in_mux.sv: one seven bit input selector to one peripheral input
// assumes: pins and virtual sources are synchronous to the clock
`timescale 1ns/100ps
`default_nettype none
`include "pps_defines.svh"
module pps_in_mux #(
  parameter int NPINS    = 128,
  parameter bit HAS_ENC  = 1'b1
)(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic [6:0]       sel,
  input  wire logic [NPINS-1:0] pins,
  input  wire pps_pkg::pps_virt_t src,
  output logic                  q
);
  logic next_q;

  always_comb
  begin
    next_q = 1'b0;
    case (sel)
      `PPS_CODE_LOW:    next_q = 1'b0;
      `PPS_CODE_COMP1:  next_q = src.virt[0];
      `PPS_CODE_COMP2:  next_q = src.virt[1];
      `PPS_CODE_COMP3:  next_q = src.virt[2];
      `PPS_CODE_TRIG0:  next_q = src.virt[3];
      `PPS_CODE_TRIG1:  next_q = src.virt[4];
      `PPS_CODE_INDX_A: next_q = HAS_ENC & src.enc[0];
      `PPS_CODE_HOME_A: next_q = HAS_ENC & src.enc[1];
      `PPS_CODE_INDX_B: next_q = HAS_ENC & src.enc[2];
      `PPS_CODE_HOME_B: next_q = HAS_ENC & src.enc[3];
      default:
      begin
        // codes beyond the pin range read low
        if (int'(sel) < NPINS)
          next_q = pins[sel];
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      q <= 1'b0;
    else if (ce)
      q <= next_q;
  end
endmodule
`default_nettype wire

// ===== pps_pkg.sv
// pps_pkg.sv: types shared by the pin select modules
// assumes: codes and offsets come from pps_defines.svh
package pps_pkg;
  typedef struct packed {
    logic [5:0] virt;
    logic [3:0] enc;
  } pps_virt_t;

  typedef struct packed {
    logic [6:0] hi;
    logic [6:0] lo;
  } pps_in_pair_t;

  typedef struct packed {
    logic [5:0] hi;
    logic [5:0] lo;
  } pps_out_pair_t;
endpackage

// ===== pps_top.sv
// pps_top.sv: peripheral pin select with apb register access
// assumes: apb master keeps the request stable until pready
//
// What this block does
// - each peripheral input follows its own selector
// - input selectors are seven bits, packed
// - selector value n from 10 up picks remappable pin n
// - values past implemented pins are out of range
// - code 0 low, 1 comparator1, 121 pin 121
// - comparator and trigger outputs are virtual sources
// - fault1 selector value 1 takes comparator1
// - encoder filtered index and home selectable
// - six bit output selector per pin
// - odd pin bits 13:8, even pin 5:0
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "pps_defines.svh"
module pps_top #(
  parameter int NPINS   = 128,
  parameter int NFUNCS  = 64,
  parameter bit HAS_ENC = 1'b1
)(
  input  wire logic              MCLK,
  input  wire logic              RST,
  input  wire logic              CE,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [11:0]       PADDR,
  input  wire logic [31:0]       PWDATA,
  input  wire logic [3:0]        PSTRB,
  output logic                   PREADY,
  output logic [31:0]            PRDATA,
  output logic                   PSLVERR,
  input  wire logic [NPINS-1:0]  PIN_IN,
  input  wire logic [5:0]        VIRT_SRC,
  input  wire logic [3:0]        ENC_FILTERED,
  input  wire logic [NFUNCS-1:0] FUNC_OUT,
  output logic                   SPI2_CLK_IN,
  output logic                   SPI2_DATA_IN,
  output logic                   PWM_FAULT1_IN,
  output logic                   CAPTURE1_IN,
  output logic [3:0]             PIN_OUT,
  output logic [3:0]             PIN_OUT_EN
);
  pps_pkg::pps_in_pair_t  spi2_input_select;
  pps_pkg::pps_in_pair_t  aux_input_select;
  pps_pkg::pps_out_pair_t output_select_pins_42_43;
  pps_pkg::pps_out_pair_t output_select_pins_54_55;
  pps_pkg::pps_virt_t     src;
  logic                   setup;
  logic                   wr;
  logic                   known;
  logic [31:0]            next_rdata;
  logic [5:0]             osel [4];
  logic [3:0]             next_out;
  logic [3:0]             next_en;

  function automatic logic [31:0] in_word(pps_pkg::pps_in_pair_t p);
    in_word = {16'h0000, 1'b0, p.hi, 1'b0, p.lo};
  endfunction

  function automatic logic [31:0] out_word(pps_pkg::pps_out_pair_t p);
    out_word = {16'h0000, 2'b00, p.hi, 2'b00, p.lo};
  endfunction

  function automatic pps_pkg::pps_in_pair_t in_pair(logic [31:0] w);
    in_pair.hi = w[`PPS_IN_HI_LSB +: `PPS_IN_W];
    in_pair.lo = w[`PPS_IN_LO_LSB +: `PPS_IN_W];
  endfunction

  function automatic pps_pkg::pps_out_pair_t out_pair(logic [31:0] w);
    out_pair.hi = w[`PPS_OUT_HI_LSB +: `PPS_OUT_W];
    out_pair.lo = w[`PPS_OUT_LO_LSB +: `PPS_OUT_W];
  endfunction

  // write a byte lane only where its strobe is set
  function automatic logic [31:0] merge(logic [31:0] old,
                                        logic [31:0] nw,
                                        logic [3:0]  st,
                                        logic [31:0] msk);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (st[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    end
    merge = r & msk;
  endfunction

  assign setup = PSEL & ~PENABLE;
  assign wr    = PSEL & PENABLE & PREADY & PWRITE;
  assign known = (PADDR == `PPS_OFF_SPI2_IN) ||
                 (PADDR == `PPS_OFF_OUT_42_43) ||
                 (PADDR == `PPS_OFF_OUT_54_55) ||
                 (PADDR == `PPS_OFF_PFAULT_IN) ||
                 (PADDR == `PPS_OFF_CAPTURE_IN);
  assign src.virt = VIRT_SRC;
  assign src.enc  = ENC_FILTERED;

  // no wait states: ready rises in the first access cycle
  always_ff @(posedge MCLK)
  begin
    if (RST)
      PREADY <= 1'b0;
    else if (CE)
      PREADY <= setup;
  end

  always_comb
  begin
    next_rdata = 32'h00000000;
    if (PADDR == `PPS_OFF_SPI2_IN)
      next_rdata = in_word(spi2_input_select);
    else if (PADDR == `PPS_OFF_OUT_42_43)
      next_rdata = out_word(output_select_pins_42_43);
    else if (PADDR == `PPS_OFF_OUT_54_55)
      next_rdata = out_word(output_select_pins_54_55);
    else if (PADDR == `PPS_OFF_PFAULT_IN)
      next_rdata = {25'h0000000, aux_input_select.lo};
    else if (PADDR == `PPS_OFF_CAPTURE_IN)
      next_rdata = {25'h0000000, aux_input_select.hi};
  end

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      PRDATA  <= 32'h00000000;
      PSLVERR <= 1'b0;
    end
    else if (CE)
    begin
      PRDATA  <= setup ? next_rdata : 32'h00000000;
      PSLVERR <= setup & ~known;
    end
  end

  // input selectors
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      spi2_input_select <= '0;
      aux_input_select  <= '0;
    end
    else if (CE && wr)
    begin
      if (PADDR == `PPS_OFF_SPI2_IN)
        spi2_input_select <= in_pair(merge(in_word(spi2_input_select),
                                     PWDATA, PSTRB, `PPS_IN_MASK));
      else if (PADDR == `PPS_OFF_PFAULT_IN && PSTRB[0])
        aux_input_select.lo <= PWDATA[6:0];
      else if (PADDR == `PPS_OFF_CAPTURE_IN && PSTRB[0])
        aux_input_select.hi <= PWDATA[6:0];
    end
  end

  // output selectors
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      output_select_pins_42_43 <= '0;
      output_select_pins_54_55 <= '0;
    end
    else if (CE && wr)
    begin
      if (PADDR == `PPS_OFF_OUT_42_43)
        output_select_pins_42_43 <= out_pair(merge(
          out_word(output_select_pins_42_43), PWDATA, PSTRB,
          `PPS_OUT_MASK));
      else if (PADDR == `PPS_OFF_OUT_54_55)
        output_select_pins_54_55 <= out_pair(merge(
          out_word(output_select_pins_54_55), PWDATA, PSTRB,
          `PPS_OUT_MASK));
    end
  end

  // function 0 means the pin is released to plain port logic
  always_comb
  begin
    osel[0] = output_select_pins_42_43.lo;
    osel[1] = output_select_pins_42_43.hi;
    osel[2] = output_select_pins_54_55.lo;
    osel[3] = output_select_pins_54_55.hi;
    next_out = 4'h0;
    next_en  = 4'h0;
    for (int i = 0; i < 4; i++)
    begin
      if (osel[i] != 6'h00 && int'(osel[i]) < NFUNCS)
      begin
        next_out[i] = FUNC_OUT[osel[i]];
        next_en[i]  = 1'b1;
      end
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      PIN_OUT    <= 4'h0;
      PIN_OUT_EN <= 4'h0;
    end
    else if (CE)
    begin
      PIN_OUT    <= next_out;
      PIN_OUT_EN <= next_en;
    end
  end

  // encoder sources are only meaningful once software enabled it
  pps_in_mux #(.NPINS(NPINS), .HAS_ENC(HAS_ENC)) u_spi2_clk (
    .clk(MCLK), .rst(RST), .ce(CE), .sel(spi2_input_select.hi),
    .pins(PIN_IN), .src(src), .q(SPI2_CLK_IN));
  pps_in_mux #(.NPINS(NPINS), .HAS_ENC(HAS_ENC)) u_spi2_dat (
    .clk(MCLK), .rst(RST), .ce(CE), .sel(spi2_input_select.lo),
    .pins(PIN_IN), .src(src), .q(SPI2_DATA_IN));
  pps_in_mux #(.NPINS(NPINS), .HAS_ENC(HAS_ENC)) u_fault1 (
    .clk(MCLK), .rst(RST), .ce(CE), .sel(aux_input_select.lo),
    .pins(PIN_IN), .src(src), .q(PWM_FAULT1_IN));
  pps_in_mux #(.NPINS(NPINS), .HAS_ENC(HAS_ENC)) u_capture1 (
    .clk(MCLK), .rst(RST), .ce(CE), .sel(aux_input_select.hi),
    .pins(PIN_IN), .src(src), .q(CAPTURE1_IN));

  a_fault_comp1: assert property (@(posedge MCLK) disable iff (RST)
    CE && aux_input_select.lo == `PPS_CODE_COMP1 ##1 CE
    |-> PWM_FAULT1_IN == $past(VIRT_SRC[0]))
    else $error("fault1 not fed by comparator1");
  a_code_zero_low: assert property (@(posedge MCLK) disable iff (RST)
    CE && spi2_input_select.lo == `PPS_CODE_LOW ##1 CE |-> !SPI2_DATA_IN)
    else $error("code zero not low");
  a_pin_route: assert property (@(posedge MCLK) disable iff (RST)
    CE && int'(spi2_input_select.hi) > 9 && int'(spi2_input_select.hi) < NPINS
    |=> !CE || SPI2_CLK_IN == $past(PIN_IN[spi2_input_select.hi]))
    else $error("spi2 clock not from chosen pin");
  a_code_top_pin: assert property (@(posedge MCLK) disable iff (RST)
    CE && spi2_input_select.lo == `PPS_CODE_PIN_MAX
    |=> !CE || SPI2_DATA_IN == $past(PIN_IN[121]))
    else $error("code 121 not pin 121");
  a_enc_home: assert property (@(posedge MCLK) disable iff (RST)
    CE && aux_input_select.hi == `PPS_CODE_HOME_A
    |=> !CE || CAPTURE1_IN == (HAS_ENC & $past(ENC_FILTERED[1])))
    else $error("home a not routed");
  a_spi2_read: assert property (@(posedge MCLK) disable iff (RST)
    CE && setup && PADDR == `PPS_OFF_SPI2_IN
    |=> !CE || (PRDATA[15] == 1'b0 && PRDATA[7] == 1'b0 && PREADY))
    else $error("spi2 reserved bits set");
  a_out_read: assert property (@(posedge MCLK) disable iff (RST)
    CE && setup && PADDR == `PPS_OFF_OUT_42_43
    |=> !CE || (PRDATA[15:14] == 2'b00 && PRDATA[7:6] == 2'b00))
    else $error("output reserved bits set");
  a_out_drive: assert property (@(posedge MCLK) disable iff (RST)
    CE && output_select_pins_42_43.hi == 6'h00 |=> !CE || !PIN_OUT_EN[1])
    else $error("pin driven with no function");
  a_reset_zero: assert property (@(posedge MCLK)
    RST |=> spi2_input_select == '0 && output_select_pins_54_55 == '0)
    else $error("selectors not cleared");
  a_spi2_write: assert property (@(posedge MCLK) disable iff (RST)
    CE && wr && PADDR == `PPS_OFF_SPI2_IN && PSTRB[1:0] == 2'b11
    |=> spi2_input_select == {$past(PWDATA[14:8]), $past(PWDATA[6:0])})
    else $error("spi2 selector write misplaced");
  a_lane_keep: assert property (@(posedge MCLK) disable iff (RST)
    CE && wr && PADDR == `PPS_OFF_SPI2_IN && PSTRB[1:0] == 2'b10
    |=> spi2_input_select.lo == $past(spi2_input_select.lo))
    else $error("spi2 data selector changed by lane one");
  a_out_write: assert property (@(posedge MCLK) disable iff (RST)
    CE && wr && PADDR == `PPS_OFF_OUT_54_55 && PSTRB[1:0] == 2'b11
    |=> output_select_pins_54_55.hi == $past(PWDATA[13:8])
        && output_select_pins_54_55.lo == $past(PWDATA[5:0]))
    else $error("output selector write misplaced");
  a_aux_read: assert property (@(posedge MCLK) disable iff (RST)
    CE && setup && PADDR == `PPS_OFF_PFAULT_IN
    |=> !CE || PRDATA[31:7] == '0)
    else $error("fault1 selector read has extra bits");
  a_out_func: assert property (@(posedge MCLK) disable iff (RST)
    CE && output_select_pins_42_43.hi == 6'h01
    |=> !CE || (PIN_OUT_EN[1] && PIN_OUT[1] == $past(FUNC_OUT[1])))
    else $error("pin 43 not driven by function one");
  a_enc_index: assert property (@(posedge MCLK) disable iff (RST)
    CE && spi2_input_select.hi == `PPS_CODE_INDX_A
    |=> !CE || SPI2_CLK_IN == (HAS_ENC & $past(ENC_FILTERED[0])))
    else $error("index a not routed");
  a_trig_src: assert property (@(posedge MCLK) disable iff (RST)
    CE && aux_input_select.lo == `PPS_CODE_TRIG0
    |=> !CE || PWM_FAULT1_IN == $past(VIRT_SRC[3]))
    else $error("trigger output zero not routed");
  a_fault_pin: assert property (@(posedge MCLK) disable iff (RST)
    CE && int'(aux_input_select.lo) > 9 && int'(aux_input_select.lo) < NPINS
    |=> !CE || PWM_FAULT1_IN == $past(PIN_IN[aux_input_select.lo]))
    else $error("fault1 not from chosen pin");
  a_reset_out: assert property (@(posedge MCLK)
    RST |=> PIN_OUT_EN == 4'h0 && !SPI2_CLK_IN && !SPI2_DATA_IN
            && !PWM_FAULT1_IN && !CAPTURE1_IN)
    else $error("outputs not cleared by reset");
  a_pin54_idle: assert property (@(posedge MCLK) disable iff (RST)
    CE && output_select_pins_54_55.lo == 6'h00 |=> !CE || !PIN_OUT_EN[2])
    else $error("pin 54 driven with no function");
  c_write: cover property (@(posedge MCLK) wr);
  c_freeze: cover property (@(posedge MCLK) !CE && SPI2_DATA_IN);
  c_fault: cover property (@(posedge MCLK) PWM_FAULT1_IN);
  c_drive: cover property (@(posedge MCLK) PIN_OUT_EN[3]);
  c_err: cover property (@(posedge MCLK) PSLVERR);
endmodule
`default_nettype wire
